// file: sfr_pkg.sv
// Purpose : constants, types and formats of the serial flash fast read engine
// Assumes : the serial clock and pins arrive asynchronous to clk
// Notes   : every count is in serial clocks unless the name says otherwise
//
// How it works
// - single fast read: opcode, 24-bit address, eight dummies
// - output undefined during single-line dummy clocks
// - four-wire mode fast read dummies 2/4/6/8
// - reset sets four-wire dummy count to 2
// - dual output read: eight dummies, two-bit data
// - quad output read needs quad enable bit
// - dual I/O read: address two bits per clock
// - mode byte follows address; bits 5:4 used
// - skip bits 10 make next dual read opcode-less
// - skip bits 10 make next quad read opcode-less
// - other skip bits restore normal opcode decoding
// - quad I/O read: four lines, four dummies
// - quad read wraps within selected page section
// - three wrap setting bits: disable plus length
// - four-wire mode counts mode clocks as dummies
// - continuous mode works in four-wire mode
// - four-wire mode quad reads never wrap
// - word quad read: even address, two dummies
// - data driven on falling edge, MSB first
// - address advances after every byte fetched into the buffer
// - wrap disable bit resets to one
package sfr_pkg;
   localparam logic [7:0] OP_FAST_READ     = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
   localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
   localparam logic [7:0] OP_DUAL_IO_READ  = 8'hBB;
   localparam logic [7:0] OP_QUAD_IO_READ  = 8'hEB;
   localparam logic [7:0] OP_WORD_QUAD_READ = 8'hE7;

   localparam int         ADDR_BITS          = 24;
   localparam logic [3:0] SPI_FAST_DUMMY     = 4'd8;
   localparam logic [3:0] SPI_QUAD_IO_DUMMY  = 4'd4;
   localparam logic [3:0] SPI_WORD_DUMMY     = 4'd2;
   localparam logic [3:0] DUAL_MODE_CLKS     = 4'd4;
   localparam logic [3:0] QUAD_MODE_CLKS     = 4'd2;
   localparam logic [4:0] SPI_OPCODE_CLKS    = 5'd8;
   localparam logic [4:0] QPI_OPCODE_CLKS    = 5'd2;
   localparam logic [1:0] OPCODE_SKIP_VALUE  = 2'b10;
   localparam int         OPCODE_SKIP_LSB    = 4;
   localparam logic [1:0] READ_DUMMY_RESET   = 2'b00;
   localparam logic [2:0] WRAP_SETTING_RESET = 3'b001;
   localparam int         WRAP_DISABLE_POS   = 0;
   localparam int         WRAP_LENGTH_LSB    = 1;
   localparam logic [8:0] WRAP_BASE_BYTES    = 9'd8;
   localparam logic [7:0] EMPTY_BYTE         = 8'hFF;

   typedef enum logic [2:0] {
      ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
   } sfr_state_e;

   typedef struct packed {
      logic       ok;
      logic [2:0] addrLanes;
      logic [2:0] dataLanes;
      logic [3:0] modeClks;
      logic [3:0] dummyClks;
      logic       wrapOk;
      logic       contOk;
   } sfr_format_s;

   typedef struct packed {
      logic       csN;
      logic       sclk;
      logic [3:0] io;
   } sfr_pins_s;
endpackage

// file: sfr_sync.sv
// Purpose : two-flop synchroniser for a group of pin levels
// Assumes : each bit is an independent level
// Notes   : the first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module sfr_sync #(
   parameter int              WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta <= RESET_VAL;
         q    <= RESET_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// file: sfr_fifo.sv
// Purpose : byte buffer between the array fetch and the pin shifter
// Assumes : single clock, flush empties it at once
// Notes   : inReady is a register so it can leave the block directly
`timescale 1ns/100ps
`default_nettype none
module sfr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             flush,
   // fill side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   // drain side
   output logic                  outValid,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
      $error("fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   logic [AW:0]      next_count;

   assign push       = inValid && inReady;
   assign pop        = outValid && outReady;
   assign outValid   = (count != '0);
   assign outData    = mem[rdPtr];
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || flush) begin
         wrPtr   <= '0;
         rdPtr   <= '0;
         count   <= '0;
         inReady <= 1'b0;
      end else begin
         wrPtr   <= wrPtr + AW'(push);
         rdPtr   <= rdPtr + AW'(pop);
         count   <= next_count;
         inReady <= (next_count != (AW+1)'(DEPTH));
      end
   end
endmodule
`default_nettype wire

// file: sfr_fast_read_engine.sv
// Purpose : decode and sequence the fast read command family at the pins
// Assumes : clk is much faster than the serial clock; array answers memReq
// Notes   : pins pass two flops; edges of the serial clock come from clk
`timescale 1ns/100ps
`default_nettype none
module sfr_fast_read_engine
   import sfr_pkg::*;
#(
   parameter int FIFO_DEPTH = 32
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // serial pins
   input  wire logic                 csN,
   input  wire logic                 sclk,
   input  wire logic [3:0]           ioIn,
   output logic      [3:0]           ioOut,
   output logic      [3:0]           ioOe,
   // configuration from the rest of the device
   input  wire logic                 quadIoEnable,
   input  wire logic                 fourWireCommandMode,
   input  wire logic                 softReset,
   input  wire logic                 readParamLoad,
   input  wire logic [1:0]           readParamValue,
   input  wire logic                 wrapLoad,
   input  wire logic [2:0]           wrapValue,
   // array fetch
   output logic                      memReq,
   output logic      [ADDR_BITS-1:0] memAddr,
   input  wire logic                 memValid,
   input  wire logic [7:0]           memData,
   output logic                      memReady,
   // status
   output logic                      readActive,
   output logic                      continuousMode,
   output logic      [1:0]           readDummyCode,
   output logic      [2:0]           wrapSettingBits
);
   if (FIFO_DEPTH < 2) begin : g_check
      $error("FIFO_DEPTH must be at least 2");
   end

   sfr_pins_s        pinsRaw;
   sfr_pins_s        pins;
   logic             sclkPrev;
   logic             sclkRise;
   logic             sclkFall;
   logic             deselected;
   sfr_state_e       state;
   sfr_format_s      fmt;
   sfr_format_s      decoded;
   sfr_format_s      contFmt;
   logic [4:0]       cnt;
   logic [7:0]       opShift;
   logic [7:0]       next_op;
   logic [ADDR_BITS-1:0] addrShift;
   logic [ADDR_BITS-1:0] next_addr;
   logic [7:0]       modeShift;
   logic [7:0]       next_mode;
   logic [7:0]       contOpcode;
   logic             startFetch;
   logic             wrapOn;
   logic [7:0]       wrapMask;
   logic             fetchTake;
   logic [7:0]       outShift;
   logic [2:0]       outCnt;
   logic             fifoPop;
   logic             fifoValid;
   logic [7:0]       fifoData;
   logic [7:0]       outByte;

   // pin synchronisers
   assign pinsRaw = '{csN: csN, sclk: sclk, io: ioIn};

   sfr_sync #(
      .WIDTH     (6),
      .RESET_VAL (6'b10_0000)
   ) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (pinsRaw),
      .q    (pins)
   );

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sclkPrev <= 1'b0;
      end else begin
         sclkPrev <= pins.sclk;
      end
   end

   assign sclkRise   = pins.sclk && !sclkPrev;
   assign sclkFall   = !pins.sclk && sclkPrev;
   assign deselected = pins.csN;

   // shift helpers
   function automatic logic [ADDR_BITS-1:0] shift_in(
      input logic [ADDR_BITS-1:0] val,
      input logic [2:0]           lanes,
      input logic [3:0]           io
   );
      case (lanes)
         3'd2:    shift_in = {val[ADDR_BITS-3:0], io[1:0]};
         3'd4:    shift_in = {val[ADDR_BITS-5:0], io[3:0]};
         default: shift_in = {val[ADDR_BITS-2:0], io[0]};
      endcase
   endfunction

   function automatic logic [4:0] addr_clks(input logic [2:0] lanes);
      case (lanes)
         3'd2:    addr_clks = 5'd12;
         3'd4:    addr_clks = 5'd6;
         default: addr_clks = 5'd24;
      endcase
   endfunction

   function automatic logic [3:0] pin_bits(
      input logic [7:0] b,
      input logic [2:0] lanes
   );
      case (lanes)
         3'd2:    pin_bits = {2'b00, b[7:6]};
         3'd4:    pin_bits = b[7:4];
         default: pin_bits = {2'b00, b[7], 1'b0};
      endcase
   endfunction

   // opcode table
   function automatic sfr_format_s decode(
      input logic [7:0] op,
      input logic       four_wire_command_mode,
      input logic       qe,
      input logic [1:0] dummyCode
   );
      logic [3:0] qpiDummy;
      qpiDummy = {1'b0, dummyCode, 1'b0} + 4'd2;
      decode   = '0;
      case (op)
         OP_FAST_READ: begin
            decode.ok        = 1'b1;
            decode.addrLanes = four_wire_command_mode ? 3'd4 : 3'd1;
            decode.dataLanes = four_wire_command_mode ? 3'd4 : 3'd1;
            decode.dummyClks = four_wire_command_mode ? qpiDummy : SPI_FAST_DUMMY;
         end
         OP_DUAL_OUT_READ: begin
            decode.ok        = !four_wire_command_mode;
            decode.addrLanes = 3'd1;
            decode.dataLanes = 3'd2;
            decode.dummyClks = SPI_FAST_DUMMY;
         end
         OP_QUAD_OUT_READ: begin
            decode.ok        = !four_wire_command_mode && qe;
            decode.addrLanes = 3'd1;
            decode.dataLanes = 3'd4;
            decode.dummyClks = SPI_FAST_DUMMY;
         end
         OP_DUAL_IO_READ: begin
            decode.ok        = !four_wire_command_mode;
            decode.addrLanes = 3'd2;
            decode.dataLanes = 3'd2;
            decode.modeClks  = DUAL_MODE_CLKS;
            decode.contOk    = 1'b1;
         end
         OP_QUAD_IO_READ: begin
            decode.ok        = qe;
            decode.addrLanes = 3'd4;
            decode.dataLanes = 3'd4;
            decode.modeClks  = QUAD_MODE_CLKS;
            // mode clocks count toward the configured dummies
            decode.dummyClks = four_wire_command_mode ? qpiDummy - QUAD_MODE_CLKS
                                   : SPI_QUAD_IO_DUMMY;
            decode.wrapOk    = !four_wire_command_mode;
            decode.contOk    = 1'b1;
         end
         OP_WORD_QUAD_READ: begin
            decode.ok        = !four_wire_command_mode && qe;
            decode.addrLanes = 3'd4;
            decode.dataLanes = 3'd4;
            decode.modeClks  = QUAD_MODE_CLKS;
            decode.dummyClks = SPI_WORD_DUMMY;
            decode.wrapOk    = 1'b1;
            decode.contOk    = 1'b1;
         end
         default: decode = '0;
      endcase
   endfunction

   // opcode assembly: one bit per clock, or a nibble in four-wire mode
   assign next_op = fourWireCommandMode ? {opShift[3:0], pins.io}
                                        : {opShift[6:0], pins.io[0]};
   assign decoded = decode(next_op, fourWireCommandMode, quadIoEnable, readDummyCode);
   assign contFmt = decode(contOpcode, fourWireCommandMode, quadIoEnable, readDummyCode);
   assign next_addr = shift_in(addrShift, fmt.addrLanes, pins.io);
   assign next_mode = 8'(shift_in({16'h0000, modeShift}, fmt.addrLanes, pins.io));
   assign startFetch = (state == ST_ADDR) && sclkRise && (cnt == 5'd1);

   // read configuration kept across commands
   always_ff @(posedge clk) begin
      if (!rstn || softReset) begin
         readDummyCode <= READ_DUMMY_RESET;
      end else if (readParamLoad) begin
         readDummyCode <= readParamValue;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || softReset) begin
         wrapSettingBits <= WRAP_SETTING_RESET;
      end else if (wrapLoad) begin
         wrapSettingBits <= wrapValue;
      end
   end

   // command sequencer, advanced on serial clock rising edges
   always_ff @(posedge clk) begin
      if (!rstn || deselected) begin
         state     <= ST_IDLE;
         cnt       <= '0;
         fmt       <= '0;
         opShift   <= '0;
         addrShift <= '0;
         modeShift <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               opShift <= '0;
               if (continuousMode) begin
                  // opcode omitted: address follows select directly
                  state <= ST_ADDR;
                  fmt   <= contFmt;
                  cnt   <= addr_clks(contFmt.addrLanes);
               end else begin
                  state <= ST_OPCODE;
                  cnt   <= fourWireCommandMode ? QPI_OPCODE_CLKS : SPI_OPCODE_CLKS;
               end
            end
            ST_OPCODE: begin
               if (sclkRise) begin
                  opShift <= next_op;
                  cnt     <= cnt - 5'd1;
                  if (cnt == 5'd1) begin
                     fmt <= decoded;
                     cnt <= addr_clks(decoded.addrLanes);
                     state <= decoded.ok ? ST_ADDR : ST_IGNORE;
                  end
               end
            end
            ST_ADDR: begin
               if (sclkRise) begin
                  addrShift <= next_addr;
                  cnt       <= cnt - 5'd1;
                  if (cnt == 5'd1) begin
                     if (fmt.modeClks != '0) begin
                        state <= ST_MODE;
                        cnt   <= {1'b0, fmt.modeClks};
                     end else if (fmt.dummyClks != '0) begin
                        state <= ST_DUMMY;
                        cnt   <= {1'b0, fmt.dummyClks};
                     end else begin
                        state <= ST_DATA;
                     end
                  end
               end
            end
            ST_MODE: begin
               if (sclkRise) begin
                  modeShift <= next_mode;
                  cnt       <= cnt - 5'd1;
                  if (cnt == 5'd1) begin
                     if (fmt.dummyClks != '0) begin
                        state <= ST_DUMMY;
                        cnt   <= {1'b0, fmt.dummyClks};
                     end else begin
                        state <= ST_DATA;
                     end
                  end
               end
            end
            ST_DUMMY: begin
               if (sclkRise) begin
                  cnt <= cnt - 5'd1;
                  if (cnt == 5'd1) begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_DATA:   state <= ST_DATA;
            ST_IGNORE: state <= ST_IGNORE;
            default:   state <= ST_IDLE;
         endcase
      end
   end

   // continuous read mode: decided by the skip bits of the mode byte
   always_ff @(posedge clk) begin
      if (!rstn || softReset) begin
         continuousMode <= 1'b0;
         contOpcode     <= '0;
      end else if (state == ST_OPCODE && sclkRise && cnt == 5'd1) begin
         contOpcode <= next_op;
      end else if (state == ST_MODE && sclkRise && cnt == 5'd1 && fmt.contOk) begin
         // only bits 5:4 matter; the other six bits are ignored
         continuousMode <= (next_mode[OPCODE_SKIP_LSB +: 2] == OPCODE_SKIP_VALUE);
      end
   end

   // array fetch with page-section wrap
   function automatic logic [ADDR_BITS-1:0] advance(
      input logic [ADDR_BITS-1:0] a,
      input logic                 wrap,
      input logic [7:0]           mask
   );
      logic [ADDR_BITS-1:0] inc;
      inc = a + ADDR_BITS'(1);
      if (wrap) begin
         advance = {a[ADDR_BITS-1:8], (a[7:0] & ~mask) | (inc[7:0] & mask)};
      end else begin
         advance = inc;
      end
   endfunction

   assign fetchTake = memReq && memValid && memReady;

   always_ff @(posedge clk) begin
      if (!rstn || deselected) begin
         memReq   <= 1'b0;
         memAddr  <= '0;
         wrapOn   <= 1'b0;
         wrapMask <= '0;
      end else if (startFetch) begin
         memReq   <= 1'b1;
         memAddr  <= next_addr;
         wrapOn   <= fmt.wrapOk && !fourWireCommandMode
                     && !wrapSettingBits[WRAP_DISABLE_POS];
         wrapMask <= 8'((WRAP_BASE_BYTES << wrapSettingBits[WRAP_LENGTH_LSB +: 2])
                        - 9'd1);
      end else if (fetchTake) begin
         memAddr <= advance(memAddr, wrapOn, wrapMask);
      end
   end

   sfr_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rstn     (rstn),
      .flush    (deselected),
      .inValid  (memValid && memReq),
      .inData   (memData),
      .inReady  (memReady),
      .outValid (fifoValid),
      .outData  (fifoData),
      .outReady (fifoPop)
   );

   // output shifter on serial clock falling edges
   assign fifoPop = sclkFall && (state == ST_DATA) && (outCnt == '0);
   assign outByte = fifoValid ? fifoData : EMPTY_BYTE;

   always_ff @(posedge clk) begin
      if (!rstn || deselected) begin
         ioOut    <= '0;
         ioOe     <= '0;
         outShift <= '0;
         outCnt   <= '0;
      end else if (sclkFall && state == ST_DATA) begin
         case (fmt.dataLanes)
            3'd2:    ioOe <= 4'b0011;
            3'd4:    ioOe <= 4'b1111;
            default: ioOe <= 4'b0010;
         endcase
         if (outCnt == '0) begin
            ioOut    <= pin_bits(outByte, fmt.dataLanes);
            outShift <= outByte << fmt.dataLanes;
            outCnt   <= 3'(4'd8 / {1'b0, fmt.dataLanes} - 4'd1);
         end else begin
            ioOut    <= pin_bits(outShift, fmt.dataLanes);
            outShift <= outShift << fmt.dataLanes;
            outCnt   <= outCnt - 3'd1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         readActive <= 1'b0;
      end else begin
         readActive <= (state == ST_DATA);
      end
   end
endmodule
`default_nettype wire

// file: sfr_engine_monitor.sv
// Purpose : port assertions of the fast read engine
// Assumes : one clock, rstn synchronous active low
// Notes   : bound to the engine after the module
`timescale 1ns/100ps
`default_nettype none
module sfr_engine_monitor
   import sfr_pkg::*;
#(
   parameter int FIFO_DEPTH = 32
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // pins and configuration
   input wire logic        csN,
   input wire logic [3:0]  ioOe,
   input wire logic        quadIoEnable,
   input wire logic        softReset,
   input wire logic        readParamLoad,
   input wire logic [1:0]  readParamValue,
   input wire logic        wrapLoad,
   input wire logic [2:0]  wrapValue,
   // fetch and status
   input wire logic        memReq,
   input wire logic [23:0] memAddr,
   input wire logic        memValid,
   input wire logic        memReady,
   input wire logic        continuousMode,
   input wire logic [1:0]  readDummyCode,
   input wire logic [2:0]  wrapSettingBits
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_param_load: assert property (
      readParamLoad && !softReset |=> readDummyCode == $past(readParamValue))
      else $error("dummy code not loaded");
   a_soft_reset: assert property (
      softReset |=> readDummyCode == 2'b00 && wrapSettingBits == 3'b001 && !continuousMode)
      else $error("soft reset missed");
   a_wrap_load: assert property (
      wrapLoad && !softReset |=> wrapSettingBits == $past(wrapValue))
      else $error("wrap bits not loaded");
   a_reset_values: assert property (
      !$past(rstn) |-> readDummyCode == 2'b00 && wrapSettingBits == 3'b001)
      else $error("bad values after reset");
   a_quad_gated: assert property (
      |ioOe[3:2] |-> quadIoEnable)
      else $error("upper lanes driven without quad enable");
   a_addr_steps: assert property (
      memReq && memValid && memReady |=> !memReq || memAddr == $past(memAddr) + 24'h1
         || (memAddr[23:6] == $past(memAddr[23:6]) && memAddr < $past(memAddr)))
      else $error("fetch address did not step");
   a_fetch_stops: assert property (
      $rose(csN) |-> ##[1:8] !memReq)
      else $error("fetch outlived select");
   a_mode_in_frame: assert property (
      $changed(continuousMode) && !$past(softReset) |-> !$past(csN, 6))
      else $error("continuous mode changed outside a frame");
endmodule
bind sfr_fast_read_engine sfr_engine_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon_u (
   .clk, .rstn, .csN, .ioOe, .quadIoEnable, .softReset, .readParamLoad, .readParamValue,
   .wrapLoad, .wrapValue, .memReq, .memAddr, .memValid, .memReady, .continuousMode,
   .readDummyCode, .wrapSettingBits);
`default_nettype wire

// file: sfr_host_model.sv
// Purpose : behavioural host driving the serial pins
// Assumes : sclk idles low, half period 16 ns
// Notes   : released lanes toggle so stale levels never pass
`timescale 1ns/100ps
`default_nettype none
module sfr_host_model (
   // pins
   output logic            csN,
   output logic            sclk,
   output logic      [3:0] ioIn,
   input  wire logic [3:0] ioOut,
   input  wire logic [3:0] ioOe
);
   logic [3:0] hostIo;
   assign ioIn = (ioOe & ioOut) | (~ioOe & hostIo);
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      hostIo = 4'h0;
   end
   // fall, drive or release, rise, sample just before the next fall
   task automatic tick(input logic [3:0] d, input logic drive, output logic [3:0] s);
      sclk = 1'b0;
      hostIo = drive ? d : ~hostIo;
      #16 sclk = 1'b1;
      #16 s = ioIn;
   endtask
   task automatic sel(input logic on);
      sclk = 1'b0;
      #16 csN = !on;
      #32;
   endtask
   task automatic send(input int lanes, input int w, input logic [31:0] v);
      logic [3:0] s;
      for (int i = w - 1; i >= 0; i -= lanes) begin
         tick(lanes == 4 ? v[i -: 4] : lanes == 2 ? {2'b00, v[i -: 2]} : {3'b000, v[i]},
              1'b1, s);
      end
   endtask
   task automatic recv(input int lanes, input int clks, output logic [31:0] v);
      logic [3:0] s;
      v = '0;
      repeat (clks) begin
         tick(4'h0, 1'b0, s);
         v = lanes == 1 ? {v[30:0], s[1]} : lanes == 2 ? {v[29:0], s[1:0]} : {v[27:0], s};
      end
   endtask
endmodule
`default_nettype wire

// file: sfr_fast_read_engine_tb_top.sv
// Purpose : self-checking bench of the fast read engine
// Assumes : behavioural host and array, clk 250 MHz
// Notes   : array byte is its low address byte xor 5A
`timescale 1ns/100ps
`default_nettype none
module sfr_fast_read_engine_tb_top;
   import sfr_pkg::*;
   logic        clk, rstn, csN, sclk, quadIoEnable, fourWireCommandMode, softReset;
   logic        readParamLoad, wrapLoad, memReq, memValid, memReady, readActive;
   logic        continuousMode, sawOe, sawFull;
   logic [3:0]  ioIn, ioOut, ioOe;
   logic [1:0]  readParamValue, readDummyCode;
   logic [2:0]  wrapValue, wrapSettingBits, stall;
   logic [23:0] memAddr;
   logic [7:0]  memData, msk;
   logic [31:0] v;
   int          failCount, samplesChecked;
   sfr_fast_read_engine #(.FIFO_DEPTH(32)) dut_u (
      .clk, .rstn, .csN, .sclk, .ioIn, .ioOut, .ioOe, .quadIoEnable, .fourWireCommandMode,
      .softReset, .readParamLoad, .readParamValue, .wrapLoad, .wrapValue, .memReq, .memAddr,
      .memValid, .memData, .memReady, .readActive, .continuousMode, .readDummyCode,
      .wrapSettingBits);
   sfr_host_model host_u (.csN, .sclk, .ioIn, .ioOut, .ioOe);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // array stalls one cycle in eight
   assign memData = memAddr[7:0] ^ 8'h5A;
   always @(negedge clk) begin
      stall <= stall + 3'd1;
      memValid <= memReq && stall != 3'd0;
   end
   always @(posedge clk) begin
      if (|ioOe) sawOe <= 1'b1;
      if (rstn && memReq && !memReady) sawFull <= 1'b1;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failCount++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checked %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic load(input logic isWrap, input logic [2:0] val);
      @(negedge clk);
      wrapValue = val;
      readParamValue = val[1:0];
      wrapLoad = isWrap;
      readParamLoad = !isWrap;
      @(negedge clk);
      wrapLoad = 1'b0;
      readParamLoad = 1'b0;
      @(negedge clk);
   endtask
   // op lanes 0 skips the opcode; mc 0 means no mode byte
   task automatic rd(input logic [7:0] op, input int ol, input logic [23:0] a, input int al,
                     input logic [7:0] m, input int mc, input int dm, input int dl,
                     input int n, input logic [7:0] wm);
      logic [7:0] lo;
      host_u.sel(1'b1);
      if (ol != 0) host_u.send(ol, 8, {24'h0, op});
      host_u.send(al, 24, {8'h0, a});
      if (mc != 0) host_u.send(al, 8, {24'h0, m});
      host_u.recv(1, dm, v);
      for (int i = 0; i < n; i++) begin
         host_u.recv(dl, 8 / dl, v);
         lo = (a[7:0] & ~wm) | ((a[7:0] + 8'(i)) & wm);
         check(v[7:0], lo ^ 8'h5A);
      end
      check(readActive, 1'b1);
      host_u.sel(1'b0);
   endtask
   initial begin
      rstn = 1'b0;
      {quadIoEnable, fourWireCommandMode, softReset, readParamLoad, wrapLoad} = 5'h0;
      readParamValue = 2'b00;
      wrapValue = 3'b001;
      {memValid, sawOe, sawFull, stall} = '0;
      failCount = 0;
      samplesChecked = 0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      check(readDummyCode, 2'b00);
      check(wrapSettingBits, 3'b001);
      rd(OP_FAST_READ, 1, 24'h01_2345, 1, 8'h00, 0, 8, 1, 3, 8'hFF);
      check(sawFull, 1'b1);
      rd(OP_DUAL_OUT_READ, 1, 24'h00_00FE, 1, 8'h00, 0, 8, 2, 3, 8'hFF);
      sawOe = 1'b0;
      host_u.sel(1'b1);
      host_u.send(1, 8, {24'h0, OP_QUAD_OUT_READ});
      host_u.send(1, 24, 32'h0000_0100);
      host_u.recv(4, 16, v);
      check(readActive, 1'b0);
      host_u.sel(1'b0);
      check(sawOe, 1'b0);
      quadIoEnable = 1'b1;
      rd(OP_QUAD_OUT_READ, 1, 24'h00_0200, 1, 8'h00, 0, 8, 4, 2, 8'hFF);
      rd(OP_DUAL_IO_READ, 1, 24'h00_0210, 2, 8'h20, 1, 0, 2, 2, 8'hFF);
      check(continuousMode, 1'b1);
      rd(8'h00, 0, 24'h55_5555, 2, 8'hFF, 1, 0, 2, 2, 8'hFF);
      check(continuousMode, 1'b0);
      for (int k = 0; k < 4; k++) begin
         msk = 8'((8 << k) - 1);
         load(1'b1, {2'(k), 1'b0});
         check(wrapSettingBits, {2'(k), 1'b0});
         rd(OP_QUAD_IO_READ, 1, {16'h0004, msk - 8'h01}, 4, 8'h00, 1, 4, 4, 3, msk);
      end
      load(1'b1, 3'b001);
      rd(OP_QUAD_IO_READ, 1, 24'h00_0306, 4, 8'h2F, 1, 4, 4, 3, 8'hFF);
      check(continuousMode, 1'b1);
      rd(8'h00, 0, 24'h11_1111, 4, 8'hFF, 1, 4, 4, 2, 8'hFF);
      check(continuousMode, 1'b0);
      rd(OP_WORD_QUAD_READ, 1, 24'h00_0040, 4, 8'h00, 1, 2, 4, 2, 8'hFF);
      fourWireCommandMode = 1'b1;
      for (int k = 0; k < 4; k++) begin
         load(1'b0, 3'(k));
         check(readDummyCode, 8'(k));
         rd(OP_FAST_READ, 4, 24'h00_0120, 4, 8'h00, 0, 2 * k + 2, 4, 2, 8'hFF);
      end
      load(1'b1, 3'b000);
      rd(OP_QUAD_IO_READ, 4, 24'h00_00C6, 4, 8'h20, 1, 6, 4, 4, 8'hFF);
      check(continuousMode, 1'b1);
      rd(8'h00, 0, 24'h11_1111, 4, 8'hFF, 1, 6, 4, 1, 8'hFF);
      @(negedge clk);
      softReset = 1'b1;
      @(negedge clk);
      softReset = 1'b0;
      @(negedge clk);
      check(readDummyCode, 2'b00);
      check(wrapSettingBits, 3'b001);
      rd(OP_QUAD_IO_READ, 4, 24'h00_0300, 4, 8'h00, 1, 0, 4, 2, 8'hFF);
      conclude();
   end
   // the sequence needs about 20 us of serial traffic
   initial begin
      #300000;
      failCount++;
      conclude();
   end
endmodule
`default_nettype wire
